// ==== test/ssp_peer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Far-side serial peer
// ==========================================
module ssp_peer (
    input  wire logic       clk_i,
    input  wire logic       sck_i,
    input  wire logic       sdo_i,
    input  wire logic       go_i,
    input  wire logic       gen_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] tx_i,
    output logic            sck_o,
    output logic            sdi_o,
    output logic [7:0]      rx_o
);
    logic [7:0] tx;
    logic [3:0] hc;
    logic [3:0] n;
    logic       ps;
    initial begin
        sck_o = 1'b1;
        sdi_o = 1'b0;
        ps = 1'b1;
        n = 4'h8;
        hc = 4'h0;
    end
    always @(posedge clk_i) begin
        ps <= sck_i;
        if (go_i) begin
            tx <= tx_i;
            n <= 4'h0;
            hc <= 4'h0;
        end else if (gen_i && n < 4'h8) begin
            hc <= hc + 4'h1;
            if (hc == 4'hb) begin
                hc <= 4'h0;
                sck_o <= ~sck_o;
            end
        end
        if (ps && !sck_i && n < 4'h8) begin
            sdi_o <= lsb_i ? tx[0] : tx[7];
            tx <= lsb_i ? tx >> 1 : tx << 1;
        end
        if (!ps && sck_i && n < 4'h8) begin
            rx_o <= lsb_i ? {sdo_i, rx_o[7:1]} : {rx_o[6:0], sdo_i};
            n <= n + 4'h1;
        end
        // Outside a frame the line is not held, so it keeps changing.
        if (n == 4'h8)
            sdi_o <= ~sdi_o;
    end
endmodule
`default_nettype wire

// ==== test/ssp_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"
// ==========================================
// Port-level checks
// ==========================================
module ssp_props (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [1:0]  clock_rate_select_i,
    input wire logic [2:0]  port_data_i,
    input wire logic [2:0]  port_dir_i,
    input wire logic [2:0]  shared_pin_o,
    input wire logic [2:0]  shared_pin_oe_o
);
    logic       en, ms, po2, live;
    logic [4:0] lowc;
    logic [3:0] falls;
    wire        xd = psel_i && penable_i && pready_o;
    wire        a_c = paddr_i == `SSP_ADDR_CONTROL;
    wire        a_d = paddr_i == `SSP_ADDR_DATA;
    wire        mapd = a_c || a_d || paddr_i == `SSP_ADDR_STATUS;
    wire [4:0]  half = 5'h02 << clock_rate_select_i;
    default clocking cb @(posedge clk_i);
    endclocking
    // Checks wait one edge after reset release, so outputs still holding
    // their reset values at the releasing edge are never judged.
    default disable iff (!rst_n_i || !live);
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            en <= 1'b0;
            ms <= 1'b0;
            lowc <= 5'h00;
            falls <= 4'h0;
            po2 <= 1'b1;
            live <= 1'b0;
        end else begin
            live <= 1'b1;
            if (xd && pwrite_i && a_c) begin
                en <= pwdata_i[`SSP_CTL_ENABLE_BIT];
                ms <= pwdata_i[`SSP_CTL_MASTER_BIT];
            end
            lowc <= shared_pin_o[2] ? 5'h00 : lowc + 5'h01;
            po2 <= shared_pin_o[2];
            if (xd && pwrite_i && a_d)
                falls <= 4'h0;
            else if (shared_pin_oe_o[2] && po2 && !shared_pin_o[2])
                falls <= falls + 4'h1;
        end
    end
    chk_pins_enabled: assert property (en [*2] |->
        shared_pin_oe_o[1:0] == 2'b01) else $error("data pin dirs");
    chk_clock_dir: assert property ((en && $stable(ms)) [*2] |->
        shared_pin_oe_o[2] == ms) else $error("clock pin dir");
    chk_gpio_back: assert property ((!en) [*2] |->
        shared_pin_oe_o == port_dir_i && shared_pin_o == port_data_i)
        else $error("pins not general purpose");
    chk_sck_low_time: assert property ($rose(shared_pin_o[2]) && en &&
        ms && $past(shared_pin_oe_o[2]) |-> lowc == half)
        else $error("clock low phase length");
    chk_eight_pulses: assert property (falls <= 4'h8)
        else $error("too many clock pulses");
    chk_unmapped_err: assert property (xd && !mapd |->
        pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped");
    chk_mapped_ok: assert property (xd && mapd |-> !pslverr_o)
        else $error("mapped access refused");
    chk_ctl_readback: assert property (xd && !pwrite_i && a_c |->
        prdata_o == {24'h00_0000, 1'b0, en, 1'b0, ms, 4'h0})
        else $error("control readback");
    chk_one_wait: assert property (setup_s ##1 psel_i && penable_i &&
        !pready_o |=> pready_o) else $error("answer late");
endmodule
bind ssp_top ssp_props ssp_props_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .clock_rate_select_i(clock_rate_select_i),
    .port_data_i(port_data_i), .port_dir_i(port_dir_i),
    .shared_pin_o(shared_pin_o), .shared_pin_oe_o(shared_pin_oe_o)
);
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"
module testbench;
    logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, e;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic        pready_o, pslverr_o, lsb, go, gen, psck, psdi;
    logic [1:0]  rate;
    logic [2:0]  pd, pdir, pin_i, pin_o, pin_oe;
    logic [7:0]  tx, rx, d;
    int          n_errors, total_checks;
    // Pin five has a pull-up; the others follow whoever drives them.
    assign pin_i = {pin_oe[2] ? pin_o[2] : psck,
                    pin_oe[1] ? pin_o[1] : psdi,
                    pin_oe[0] ? pin_o[0] : 1'b1};
    ssp_top ssp_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .bit_order_option_i(lsb), .clock_rate_select_i(rate),
        .port_data_i(pd), .port_dir_i(pdir), .shared_pin_i(pin_i),
        .shared_pin_o(pin_o), .shared_pin_oe_o(pin_oe));
    ssp_peer ssp_peer_inst (.clk_i(clk_i), .sck_i(pin_i[2]),
        .sdo_i(pin_i[0]), .go_i(go), .gen_i(gen), .lsb_i(lsb),
        .tx_i(tx), .sck_o(psck), .sdi_o(psdi), .rx_o(rx));
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic hang;
        n_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        complete_run;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] wd);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h00_0000, wd};
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (k >= 50)
            hang;
        d = prdata_o[7:0];
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rst(input logic l, input logic [1:0] r);
        lsb <= l;
        rate <= r;
        rst_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
    endtask
    task automatic arm(input logic [7:0] b);
        tx <= b;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
    endtask
    task automatic wdone;
        int k;
        k = 0;
        do begin
            apb(1'b0, `SSP_ADDR_STATUS, 8'h00);
            k++;
        end while (d[`SSP_STS_DONE_BIT] !== 1'b1 && k < 400);
        if (k >= 400)
            hang;
    endtask
    task automatic wlow;
        int k;
        k = 0;
        while (pin_o[2] !== 1'b0 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 100)
            hang;
    endtask
    task automatic pins(input logic [2:0] x);
        repeat (2) @(posedge clk_i);
        chk({5'h00, pin_oe}, {5'h00, x});
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_reset;
        pins(pdir);
        apb(1'b0, `SSP_ADDR_CONTROL, 8'h00);
        chk(d, `SSP_CONTROL_RESET);
        apb(1'b0, `SSP_ADDR_STATUS, 8'h00);
        chk(d, `SSP_STATUS_RESET);
        apb(1'b0, 12'h034, 8'h00);
        chk({7'h00, e}, 8'h01);
        apb(1'b1, `SSP_ADDR_CONTROL, 8'h10);
        apb(1'b0, `SSP_ADDR_CONTROL, 8'h00);
        chk(d, 8'h10);
        apb(1'b1, `SSP_ADDR_CONTROL, 8'h40);
        pins(3'b001);
        $display("reset test done");
    endtask
    task automatic t_master(input logic [7:0] b, input logic [7:0] pb);
        arm(pb);
        apb(1'b1, `SSP_ADDR_CONTROL, 8'h50);
        apb(1'b1, `SSP_ADDR_DATA, b);
        wdone;
        apb(1'b0, `SSP_ADDR_DATA, 8'h00);
        chk(d, pb);
        chk(rx, b);
        apb(1'b0, `SSP_ADDR_STATUS, 8'h00);
        chk(d, 8'h00);
        $display("master test done");
    endtask
    task automatic t_coll;
        arm(8'h00);
        apb(1'b1, `SSP_ADDR_DATA, 8'h3a);
        wlow;
        apb(1'b1, `SSP_ADDR_DATA, 8'h81);
        wdone;
        chk(d, 8'hc0);
        apb(1'b0, `SSP_ADDR_DATA, 8'h00);
        apb(1'b0, `SSP_ADDR_STATUS, 8'h00);
        chk(d, 8'h00);
        $display("collision test done");
    endtask
    task automatic t_abort(input logic [7:0] c, input logic [2:0] x);
        arm(8'h00);
        apb(1'b1, `SSP_ADDR_CONTROL, 8'h50);
        apb(1'b1, `SSP_ADDR_DATA, 8'h5a);
        wlow;
        apb(1'b1, `SSP_ADDR_CONTROL, c);
        pins(x);
        apb(1'b0, `SSP_ADDR_STATUS, 8'h00);
        chk(d, 8'h00);
        $display("abort test done");
    endtask
    task automatic t_slave;
        apb(1'b1, `SSP_ADDR_CONTROL, 8'h40);
        apb(1'b1, `SSP_ADDR_DATA, 8'h96);
        arm(8'h69);
        gen <= 1'b1;
        wdone;
        gen <= 1'b0;
        chk(rx, 8'h96);
        apb(1'b0, `SSP_ADDR_DATA, 8'h00);
        chk(d, 8'h69);
        $display("slave test done");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {psel_i, penable_i, pwrite_i, go, gen} = 5'h00;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        pd = 3'b110;
        pdir = 3'b101;
        tx = 8'h00;
        n_errors = 0;
        total_checks = 0;
        rst(1'b0, 2'b11);
        t_reset;
        t_master(8'ha5, 8'h3c);
        rst(1'b1, 2'b10);
        apb(1'b0, `SSP_ADDR_DATA, 8'h00);
        chk(d, 8'h3c);
        t_master(8'h1d, 8'hc6);
        t_coll;
        t_abort(8'h10, pdir);
        t_abort(8'h40, 3'b001);
        t_slave;
        complete_run;
    end
endmodule
`default_nettype wire

// ==== verilog/ssp_clk_div.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"

module ssp_clk_div #(
    parameter CNT_W = 8
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             run_i,
    input  wire [1:0]       rate_sel_i,
    output reg              tick_o
);

    // =====================================================================
    // Half period lookup and tick counter
    // =====================================================================
    function [CNT_W-1:0] half_period;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   half_period = `SSP_HALF_RATE_0;
                2'b01:   half_period = `SSP_HALF_RATE_1;
                2'b10:   half_period = `SSP_HALF_RATE_2;
                default: half_period = `SSP_HALF_RATE_3;
            endcase
        end
    endfunction

    reg [CNT_W-1:0] count;

    // The count restarts whenever the port is idle, so the first half
    // period of each byte is always full length.
    always @(posedge clk_i) begin
        if (!rst_n_i || !run_i) begin
            count  <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (count == half_period(rate_sel_i) - 1'b1) begin
            count  <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            count  <= count + 1'b1;
            tick_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/ssp_consts.vh ====
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// Register indices; the APB byte address is four times the index.
`define SSP_IDX_CONTROL      8'h0a
`define SSP_IDX_STATUS       8'h0b
`define SSP_IDX_DATA         8'h0c
`define SSP_ADDR_CONTROL     12'h028
`define SSP_ADDR_STATUS      12'h02c
`define SSP_ADDR_DATA        12'h030

// Field positions.
`define SSP_CTL_ENABLE_BIT   6
`define SSP_CTL_MASTER_BIT   4
`define SSP_STS_DONE_BIT     7
`define SSP_STS_COLL_BIT     6

// Reset values.
`define SSP_CONTROL_RESET    8'h00
`define SSP_STATUS_RESET     8'h00

// Bits per transfer and master clock half periods in clk_i cycles.
`define SSP_BITS_PER_XFER    4'h8
`define SSP_HALF_RATE_0      8'h02
`define SSP_HALF_RATE_1      8'h04
`define SSP_HALF_RATE_2      8'h08
`define SSP_HALF_RATE_3      8'h10

`endif

// ==== verilog/ssp_top.v ====
// Notes on behaviour
// - When enabled, data out pin is driven from the shift register's last stage.
// - First bit appears on the first falling clock edge, others on later falls.
// - A one-time option picks most or least significant bit first.
// - Control, status and data registers sit at indices 0A, 0B and 0C.
// - Enable routes shared pins to data out, data in and serial clock.
// - Clearing enable aborts a transfer, clears the bit count, frees pins.
// - In master mode a data write starts a transfer with an internal clock.
// - Data pins act the same in master and slave; only clock source differs.
// - Master select is always accessible; clearing it aborts; reset clears it.
// - Done flag is set on the last rising edge; later it only gates collision clearing.
// - Status read then data access clears done; the last edge sets it again.
// - Data access after the first fall and before done sets the collision flag.
// - Status read with done set, then data access, clears collision.
// - Reset clears both the done flag and the collision flag.
// - One unbuffered data register holds both bytes; writes overwrite it.
// - Reset leaves data unchanged; reads mid-transfer give ambiguous values.
// - Clock idles high, falls to begin, samples on rises, ends on eighth rise.
// - Data in pin is an input as soon as the port is enabled.
// - Master clock rate comes from two rate select option bits.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"

module ssp_top (
    input  wire        clk_i,
    input  wire        rst_n_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // One-time option straps, caught while reset is held
    input  wire        bit_order_option_i,
    input  wire [1:0]  clock_rate_select_i,
    // General purpose port values for pins five to seven
    input  wire [2:0]  port_data_i,
    input  wire [2:0]  port_dir_i,
    // Shared pins: [0] pin five, [1] pin six, [2] pin seven
    input  wire [2:0]  shared_pin_i,
    output reg  [2:0]  shared_pin_o,
    output reg  [2:0]  shared_pin_oe_o
);

    // =====================================================================
    // Register bus access decode
    // =====================================================================
    reg  [7:0] control;
    reg  [7:0] status;
    reg  [7:0] shift_reg;
    reg        lsb_first;
    reg  [1:0] rate_sel;

    wire       port_enable = control[`SSP_CTL_ENABLE_BIT];
    wire       master_mode = control[`SSP_CTL_MASTER_BIT];
    wire       done_flag   = status[`SSP_STS_DONE_BIT];
    wire       coll_flag   = status[`SSP_STS_COLL_BIT];

    function mapped;
        input [11:0] addr;
        begin
            mapped = (addr == `SSP_ADDR_CONTROL) ||
                     (addr == `SSP_ADDR_STATUS)  ||
                     (addr == `SSP_ADDR_DATA);
        end
    endfunction

    wire apb_done   = psel_i && penable_i && pready_o;
    wire ctl_write  = apb_done && pwrite_i &&
                      (paddr_i == `SSP_ADDR_CONTROL);
    wire sts_read   = apb_done && !pwrite_i &&
                      (paddr_i == `SSP_ADDR_STATUS);
    wire data_acc   = apb_done && (paddr_i == `SSP_ADDR_DATA);
    wire data_write = data_acc && pwrite_i;

    // One wait state: pready rises in the first access cycle's next edge.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o  <= 1'b1;
            pslverr_o <= !mapped(paddr_i);
            case (paddr_i)
                `SSP_ADDR_CONTROL: prdata_o <= {24'h00_0000, control};
                `SSP_ADDR_STATUS:  prdata_o <= {24'h00_0000, status};
                `SSP_ADDR_DATA:    prdata_o <= {24'h00_0000, shift_reg};
                default:           prdata_o <= 32'h0000_0000;
            endcase
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // =====================================================================
    // Option straps and control register
    // =====================================================================
    // Straps are sampled by a clocked process while reset is held.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            lsb_first <= bit_order_option_i;
            rate_sel  <= clock_rate_select_i;
        end
    end

    // Only the enable and master select bits exist; others read as zero.
    // A control write mid-transfer is accepted as is; the flags may then
    // misbehave, which is left to software to avoid.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            control <= `SSP_CONTROL_RESET;
        end else if (ctl_write) begin
            control <= 8'h00;
            control[`SSP_CTL_ENABLE_BIT] <= pwdata_i[`SSP_CTL_ENABLE_BIT];
            control[`SSP_CTL_MASTER_BIT] <= pwdata_i[`SSP_CTL_MASTER_BIT];
        end
    end

    // =====================================================================
    // Pin synchronisers and serial clock edge events
    // =====================================================================
    reg  [2:0] pin_meta;
    reg  [2:0] pin_sync;
    reg        sck_in_prev;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_meta    <= 3'h7;
            pin_sync    <= 3'h7;
            sck_in_prev <= 1'b1;
        end else begin
            pin_meta    <= shared_pin_i;
            pin_sync    <= pin_meta;
            sck_in_prev <= pin_sync[2];
        end
    end

    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_XFER = 2'b10;

    reg  [1:0] state;
    reg  [3:0] bit_count;
    reg        sck_master;
    reg        master_run;
    reg        serial_out;
    wire       tick;

    ssp_clk_div #(
        .CNT_W      (8)
    ) u_clk_div (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .run_i      (master_run),
        .rate_sel_i (rate_sel),
        .tick_o     (tick)
    );

    // Slave edges come from the synchronised pin, master edges from ticks.
    wire slave_fall = !master_mode && sck_in_prev && !pin_sync[2];
    wire slave_rise = !master_mode && !sck_in_prev && pin_sync[2];
    wire sck_fall   = slave_fall || (master_run && tick && sck_master);
    wire sck_rise   = slave_rise || (master_run && tick && !sck_master);
    wire last_rise  = sck_rise && (state == ST_XFER) &&
                      (bit_count == `SSP_BITS_PER_XFER - 1'b1);
    wire abort      = !port_enable || (master_run && !master_mode);
    wire sdi_bit    = pin_sync[1];
    wire out_stage  = lsb_first ? shift_reg[0] : shift_reg[7];

    // =====================================================================
    // Transfer sequencer
    // =====================================================================
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state      <= ST_IDLE;
            bit_count  <= 4'h0;
            sck_master <= 1'b1;
            master_run <= 1'b0;
            serial_out <= 1'b0;
        end else if (abort) begin
            state      <= ST_IDLE;
            bit_count  <= 4'h0;
            sck_master <= 1'b1;
            master_run <= 1'b0;
        end else begin
            if (master_run && tick) begin
                sck_master <= !sck_master;
            end
            case (state)
                ST_IDLE: begin
                    bit_count <= 4'h0;
                    if (master_mode && data_write) begin
                        state      <= ST_WAIT;
                        master_run <= 1'b1;
                    end else if (sck_fall) begin
                        state      <= ST_XFER;
                        serial_out <= out_stage;
                    end
                end
                ST_WAIT: begin
                    if (sck_fall) begin
                        state      <= ST_XFER;
                        serial_out <= out_stage;
                    end
                end
                ST_XFER: begin
                    if (sck_fall) begin
                        serial_out <= out_stage;
                    end
                    if (sck_rise) begin
                        bit_count <= bit_count + 1'b1;
                    end
                    if (last_rise) begin
                        state      <= ST_IDLE;
                        bit_count  <= 4'h0;
                        master_run <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // Shared data register
    // =====================================================================
    // No reset term, so the byte survives reset. A bus write wins over a
    // shift in the same cycle; such a write is a collision unless it lands on the eighth rise.
    always @(posedge clk_i) begin
        if (data_write) begin
            shift_reg <= pwdata_i[7:0];
        end else if (sck_rise && state == ST_XFER && port_enable) begin
            if (lsb_first) begin
                shift_reg <= {sdi_bit, shift_reg[7:1]};
            end else begin
                shift_reg <= {shift_reg[6:0], sdi_bit};
            end
        end
    end

    // =====================================================================
    // Status flags and their clearing sequence
    // =====================================================================
    reg clear_armed;
    reg coll_armed;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            status      <= `SSP_STATUS_RESET;
            clear_armed <= 1'b0;
            coll_armed  <= 1'b0;
        end else begin
            if (sts_read) begin
                clear_armed <= 1'b1;
                coll_armed  <= done_flag;
            end else if (data_acc) begin
                clear_armed <= 1'b0;
                coll_armed  <= 1'b0;
            end
            // Set wins over clear in the same cycle.
            if (last_rise) begin
                status[`SSP_STS_DONE_BIT] <= 1'b1;
            end else if (data_acc && clear_armed) begin
                status[`SSP_STS_DONE_BIT] <= 1'b0;
            end
            if (data_acc && state == ST_XFER && !last_rise) begin
                status[`SSP_STS_COLL_BIT] <= 1'b1;
            end else if (data_acc && coll_armed) begin
                status[`SSP_STS_COLL_BIT] <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Shared pin routing
    // =====================================================================
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            shared_pin_o    <= 3'h0;
            shared_pin_oe_o <= 3'h0;
        end else if (port_enable) begin
            shared_pin_o[0]    <= serial_out;
            shared_pin_oe_o[0] <= 1'b1;
            shared_pin_o[1]    <= 1'b0;
            shared_pin_oe_o[1] <= 1'b0;
            shared_pin_o[2]    <= sck_master;
            shared_pin_oe_o[2] <= master_mode;
        end else begin
            shared_pin_o    <= port_data_i;
            shared_pin_oe_o <= port_dir_i;
        end
    end

endmodule
`default_nettype wire
